/* core/key_request_link.sv */
// Behaviour
// - matching consecutive scans finish after 4800 oscillator periods, then request is raised.
// - mismatching scans trigger a rescan; total scan time is 9600 periods.
// - address 43h starts a key read; 42h carries display writes.
// - device signals pending key data by pulling its open-drain output low, except in three-wire mode while communication is on.
// - in three-wire mode one shared line carries both serial input and output.
// - a completed key read also acts as the stop command.
// - start command is accepted with the serial tick idling low or high.
`timescale 1ns/1ps
`default_nettype none
module key_request_link #(
    parameter int AGREE_TICKS = keylink_pkg::SCAN_AGREE_T,
    parameter int RETRY_TICKS = keylink_pkg::SCAN_RETRY_T,
    parameter int DIV         = keylink_pkg::OSC_DIV
) (
    input  wire logic                          clock,         // system clock, 50 MHz
    input  wire logic                          rst,           // synchronous reset, active high
    input  wire logic                          chip_select,   // strobe pin from host
    input  wire logic                          serial_tick,   // serial clock pin from host
    input  wire logic                          serial_in,     // data pin (shared line in three-wire mode)
    input  wire logic                          three_wire,    // strap: shared data line
    input  wire logic                          sleep_ack_bit, // sleep acknowledge, same clock domain
    input  wire logic [keylink_pkg::KEY_BITS-1:0] key_lines,  // raw key matrix levels
    output logic                               dout_o,        // open-drain data level, always low
    output logic                               dout_oe_n,     // low while the data line is pulled low
    output logic [7:0]                         disp_byte,     // last byte received after address 42h
    output logic                               disp_strobe    // one-cycle pulse with disp_byte
);
    import keylink_pkg::*;

    localparam logic [CNT_W-1:0] AGREE_CNT  = CNT_W'(AGREE_TICKS);
    localparam logic [CNT_W-1:0] RETRY_CNT  = CNT_W'(RETRY_TICKS);
    localparam logic [CNT_W-1:0] HALF_CNT   = CNT_W'(AGREE_TICKS / 2);
    localparam logic [CNT_W-1:0] SECOND_CNT = CNT_W'(AGREE_TICKS + AGREE_TICKS / 2);
    localparam logic [DIV_W-1:0] DIV_LAST   = DIV_W'(DIV - 1);

    if (AGREE_TICKS < 2 || RETRY_TICKS <= AGREE_TICKS + AGREE_TICKS / 2
        || RETRY_TICKS >= (1 << CNT_W) || DIV < 1 || DIV > (1 << DIV_W)) begin : g_bad_cfg
        $error("key_request_link: scan lengths or divider out of range");
    end

    typedef struct packed {
        logic [SYNC_W-1:0]   meta;
        logic [SYNC_W-1:0]   sync;
        logic                cs_prev;
        logic                tick_prev;
        logic [1:0]          warm;
        ser_e                ser;
        logic [4:0]          bits;
        logic [7:0]          addr;
        logic [7:0]          cmd;
        logic [WORD_W-1:0]   sh;
        logic                rd_valid;
        logic                comm_on;
        logic                oe_n;
        logic [7:0]          byte_out;
        logic                strobe;
        scan_e               scan;
        logic                retry;
        logic [CNT_W-1:0]    cnt;
        logic [DIV_W-1:0]    div;
        logic                osc;
        logic [KEY_BITS-1:0] snap;
        logic [KEY_BITS-1:0] last;
    } link_s;

    link_s q;
    link_s d;

    word_fifo_if #(.W(WORD_W)) kq ();

    word_fifo #(
        .W     (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_key_fifo (
        .clock (clock),
        .rst   (rst),
        .port  (kq)
    );

    logic                cs;
    logic                tck;
    logic                din;
    logic                three;
    logic [KEY_BITS-1:0] keys;
    logic                cs_rise;
    logic                cs_fall;
    logic                tick_rise;
    logic                tick_fall;
    logic                req_drive;
    logic [7:0]          cmd_next;

    assign cs        = q.sync[0];
    assign tck       = q.sync[1];
    assign din       = q.sync[2];
    assign three     = q.sync[3];
    assign keys      = q.sync[SYNC_W-1:4];
    // synchronisers read zero until they fill; a pin idling high would fake an edge
    assign cs_rise   = &q.warm && cs && !q.cs_prev;
    assign cs_fall   = &q.warm && !cs && q.cs_prev;
    // counting rising edges only makes the start command work from either idle level
    assign tick_rise = &q.warm && tck && !q.tick_prev;
    assign tick_fall = &q.warm && !tck && q.tick_prev;
    assign cmd_next  = {din, q.cmd[7:1]};

    assign dout_o      = 1'b0;
    assign dout_oe_n   = q.oe_n;
    assign disp_byte   = q.byte_out;
    assign disp_strobe = q.strobe;
    assign kq.wr_data  = {sleep_ack_bit, q.snap};
    assign kq.wr_valid = (q.scan == SC_PUSH);
    assign kq.rd_ready = (q.ser == SER_RD) && cs_fall && q.rd_valid;

    always_comb begin
        d           = q;
        d.meta      = {key_lines, three_wire, serial_in, serial_tick, chip_select};
        d.sync      = q.meta;
        d.cs_prev   = cs;
        d.tick_prev = tck;
        if (!(&q.warm)) begin
            d.warm = q.warm + 2'h1;
        end
        d.strobe    = 1'b0;
        d.osc       = 1'b0;
        d.div       = q.div + DIV_W'(1);
        if (q.div == DIV_LAST) begin
            d.div = '0;
            d.osc = 1'b1;
        end

        unique case (q.ser)
            SER_ADDR: begin
                if (cs_rise) begin
                    d.bits = '0;
                    if (q.addr == KEY_READ_ADDR) begin
                        d.ser      = SER_RD;
                        d.rd_valid = kq.rd_valid;
                        // a read without a pending request shifts out zeros, not meaningful
                        d.sh       = kq.rd_valid ? kq.rd_data : '0;
                    end else if (q.addr == DISP_WRITE_ADDR) begin
                        d.ser = SER_WR;
                    end else begin
                        d.ser = SER_SKIP;
                    end
                end else if (!cs && tick_rise) begin
                    d.bits = q.bits + 5'h01;
                    if (q.bits <= ADDR_LAST_BIT) begin
                        d.addr = {din, q.addr[7:1]};
                    end else begin
                        d.cmd = cmd_next;
                    end
                    if (q.bits == CMD_LAST_BIT && q.addr == START_ADDR) begin
                        if (cmd_next == START_CMD) begin
                            d.comm_on = 1'b1;
                        end else if (cmd_next == STOP_CMD) begin
                            d.comm_on = 1'b0;
                        end
                    end
                end
            end
            SER_RD: begin
                if (cs_fall) begin
                    d.ser      = SER_ADDR;
                    d.rd_valid = 1'b0;
                    d.comm_on  = 1'b0;
                end else if (tick_fall) begin
                    d.sh = {1'b1, q.sh[WORD_W-1:1]};
                end
            end
            SER_WR: begin
                if (cs_fall) begin
                    d.ser = SER_ADDR;
                end else if (tick_rise) begin
                    d.cmd  = cmd_next;
                    d.bits = q.bits + 5'h01;
                    if (q.bits[2:0] == 3'h7) begin
                        d.byte_out = cmd_next;
                        d.strobe   = 1'b1;
                    end
                end
            end
            SER_SKIP: begin
                if (cs_fall) begin
                    d.ser = SER_ADDR;
                end
            end
            default: d.ser = SER_ADDR;
        endcase
        if (cs_fall) begin
            d.bits = '0;
            d.addr = '0;
        end

        // three-wire: stay off the shared line while a transfer is announced
        req_drive = (d.ser == SER_ADDR) && !cs && kq.rd_valid && (!three || !d.comm_on);
        d.oe_n    = 1'b1;
        if (d.ser == SER_RD) begin
            d.oe_n = d.sh[0];
        end else if (req_drive) begin
            d.oe_n = 1'b0;
        end

        unique case (q.scan)
            SC_IDLE: begin
                // a full buffer holds off new scans until the host reads
                if (keys != q.last && kq.wr_ready) begin
                    d.scan  = SC_RUN;
                    d.cnt   = '0;
                    d.retry = 1'b0;
                end
            end
            SC_RUN: begin
                if (q.osc) begin
                    d.cnt = q.cnt + CNT_W'(1);
                    if (d.cnt == HALF_CNT || d.cnt == SECOND_CNT) begin
                        d.snap = keys;
                    end
                    if (d.cnt == AGREE_CNT) begin
                        if (keys == q.snap) begin
                            d.scan = SC_PUSH;
                        end else begin
                            d.retry = 1'b1;
                        end
                    end
                    if (d.cnt == RETRY_CNT) begin
                        d.scan = SC_PUSH;
                        d.snap = keys;
                    end
                end
            end
            SC_PUSH: begin
                if (kq.wr_ready) begin
                    d.scan = SC_IDLE;
                    d.last = q.snap;
                end
            end
            default: d.scan = SC_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            q      <= '0;
            q.ser  <= SER_ADDR;
            q.scan <= SC_IDLE;
            q.oe_n <= 1'b1;
            q.sh   <= '1;
        end else begin
            q <= d;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    chk_agree_scan_len: assert property ($rose(q.scan == SC_PUSH) && !q.retry |-> q.cnt == AGREE_CNT)
        else $error("agreeing scan did not last the short scan time");
    chk_retry_scan_len: assert property ($rose(q.scan == SC_PUSH) && q.retry |-> q.cnt == RETRY_CNT)
        else $error("rescan did not last the long scan time");
    chk_key_addr_read: assert property ((q.ser == SER_ADDR) && cs_rise
                                        && q.addr == KEY_READ_ADDR |=> q.ser == SER_RD)
        else $error("key read address did not start a read");
    chk_disp_addr_write: assert property ((q.ser == SER_ADDR) && cs_rise
                                          && q.addr == DISP_WRITE_ADDR |=> q.ser == SER_WR)
        else $error("display address did not start a write");
    chk_request_pull_low: assert property (req_drive |=> !dout_oe_n)
        else $error("pending key data not signalled low");
    chk_no_request_release: assert property ((d.ser == SER_ADDR) && !kq.rd_valid |=> dout_oe_n)
        else $error("line pulled low without pending key data");
    chk_read_bit_drive: assert property ((q.ser == SER_RD) |-> dout_oe_n == q.sh[0])
        else $error("read data bit not on the line");
    chk_read_stops_comm: assert property ((q.ser == SER_RD) && cs_fall |=> !q.comm_on && q.ser == SER_ADDR)
        else $error("completed key read did not stop communication");
    chk_start_cmd_frame: assert property ($rose(q.comm_on) |-> $past(q.bits) == CMD_LAST_BIT
                                          && $past(q.addr) == START_ADDR && $past(cmd_next) == START_CMD)
        else $error("communication started without a full start command");
    chk_start_strobe_low: assert property ($rose(q.comm_on) |-> $past(q.ser) == SER_ADDR && !$past(cs))
        else $error("start command taken outside strobe-low phase");

    cov_rescan: cover property ($rose(q.scan == SC_PUSH) && q.retry);
    cov_valid_read: cover property ((q.ser == SER_RD) && cs_fall && q.rd_valid);
    cov_start_cmd: cover property ($rose(q.comm_on));
    cov_buffer_full: cover property (!kq.wr_ready);
endmodule
`default_nettype wire

/* core/keylink_pkg.sv */
package keylink_pkg;

    localparam int KEY_BITS   = 35;
    localparam int WORD_W     = KEY_BITS + 1;
    localparam int FIFO_DEPTH = 4;
    localparam int SYNC_W     = KEY_BITS + 4;

    // scan lengths in scan-oscillator periods
    localparam int SCAN_AGREE_T = 4800;
    localparam int SCAN_RETRY_T = 9600;
    localparam int CNT_W        = 14;

    // one scan-oscillator period is OSC_DIV system clocks
    localparam int OSC_DIV = 4;
    localparam int DIV_W   = 8;

    localparam logic [7:0] KEY_READ_ADDR   = 8'h43;
    localparam logic [7:0] DISP_WRITE_ADDR = 8'h42;
    localparam logic [7:0] START_ADDR      = 8'h00;
    localparam logic [7:0] START_CMD       = 8'hEC;
    localparam logic [7:0] STOP_CMD        = 8'h6C;

    localparam logic [4:0] ADDR_LAST_BIT = 5'h07;
    localparam logic [4:0] CMD_LAST_BIT  = 5'h0F;

    typedef enum logic [3:0] {
        SER_ADDR = 4'b0001,
        SER_RD   = 4'b0010,
        SER_WR   = 4'b0100,
        SER_SKIP = 4'b1000
    } ser_e;

    typedef enum logic [2:0] {
        SC_IDLE = 3'b001,
        SC_RUN  = 3'b010,
        SC_PUSH = 3'b100
    } scan_e;

endpackage

/* core/word_fifo_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface word_fifo_if #(
    parameter int W = 8
);
    logic         wr_valid;
    logic         wr_ready;
    logic [W-1:0] wr_data;
    logic         rd_valid;
    logic         rd_ready;
    logic [W-1:0] rd_data;

    modport src   (output wr_valid, output wr_data, input wr_ready);
    modport store (input wr_valid, input wr_data, output wr_ready,
                   output rd_valid, output rd_data, input rd_ready);
    modport sink  (input rd_valid, input rd_data, output rd_ready);
endinterface
`default_nettype wire

/* core/word_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 4
) (
    input wire logic   clock, // system clock
    input wire logic   rst,   // synchronous reset, active high
    word_fifo_if.store port   // both sides of the buffer
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || W < 1) begin : g_bad_shape
        $error("word_fifo: depth must be a power of two of at least 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           rd;
        logic [CW-1:0]           count;
    } fifo_s;

    fifo_s q;
    fifo_s d;
    logic  push;
    logic  pop;

    assign port.wr_ready = (q.count != CW'(DEPTH));
    assign port.rd_valid = (q.count != '0);
    assign port.rd_data  = q.mem[q.rd];

    always_comb begin
        d    = q;
        push = port.wr_valid && port.wr_ready;
        pop  = port.rd_valid && port.rd_ready;
        if (push) begin
            // pointer wraps for free because depth is a power of two
            d.mem[q.rd + AW'(q.count)] = port.wr_data;
        end
        if (pop) begin
            d.rd = q.rd + AW'(1);
        end
        d.count = q.count + CW'(push) - CW'(pop);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule
`default_nettype wire

/* verif/key_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module key_host_model
    import keylink_pkg::*;
#(
    parameter int GUARD = 45
) (
    input  wire logic clock,       // system clock, paces the host
    input  wire logic three_wire,  // shared data line when high
    input  wire logic dout_o,      // level the device pulls to
    input  wire logic dout_oe_n,   // device pulls while low
    output var  logic chip_select, // strobe, idles low so requests show
    output var  logic serial_tick, // serial clock, still between frames
    output wire logic serial_in,   // resolved data pin at the device
    output wire logic do_line      // resolved request line seen by the host
);
    logic host_en;
    logic host_bit;

    // pull-up holds both lines high whenever nobody drives them
    assign do_line   = dout_oe_n ? 1'b1 : dout_o;
    assign serial_in = (three_wire && !do_line) ? 1'b0 : (host_en ? host_bit : 1'b1);

    initial begin
        chip_select = 1'b0;
        serial_tick = 1'b0;
        host_en     = 1'b0;
        host_bit    = 1'b1;
    end

    task automatic clk(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic send_byte(input logic [7:0] v);
        for (int i = 0; i < 8; i++) begin
            serial_tick = 1'b0;
            host_bit    = v[i];
            host_en     = 1'b1;
            clk(4);
            serial_tick = 1'b1;
            clk(4);
        end
    endtask

    // strobe rises with the clock low and the line released
    task automatic rise;
        serial_tick = 1'b0;
        host_en     = 1'b0;
        chip_select = 1'b1;
        clk(8);
    endtask

    task automatic fall(input int n);
        chip_select = 1'b0;
        clk(n);
    endtask

    task automatic command(input logic [7:0] cmd);
        send_byte(START_ADDR);
        send_byte(cmd);
        rise;
        fall(8);
    endtask

    task automatic write(input logic [7:0] addr, input logic [7:0] data);
        send_byte(addr);
        rise;
        send_byte(data);
        rise;
        fall(8);
    endtask

    task automatic key_read(output logic [36:0] w);
        send_byte(KEY_READ_ADDR);
        rise;
        for (int i = 0; i < 37; i++) begin
            serial_tick = 1'b1;
            clk(4);
            w[i]        = do_line;
            serial_tick = 1'b0;
            clk(4);
        end
        // guard outlasts the longest scan before the line is trusted again
        fall(GUARD);
    endtask
endmodule
`default_nettype wire

/* verif/key_request_link_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module key_request_link_bench;
    import keylink_pkg::*;

    localparam int AGREE = 20;
    localparam int RETRY = 40;

    typedef struct packed {
        logic [KEY_BITS-1:0] keys;
        logic                sleep;
        logic [7:0]          wbyte;
        logic [36:0]         exp_word;
    } row_s;

    // a lone key, top key with sleep acknowledge, then release of all keys
    row_s rows [3] = '{
        '{35'h000000001, 1'b0, 8'h81, 37'h1000000001},
        '{35'h400000000, 1'b1, 8'h3C, 37'h1C00000000},
        '{35'h000000000, 1'b0, 8'hFF, 37'h1000000000}
    };

    logic                clock;
    logic                rst           = 1'b1;
    logic                three_wire    = 1'b0;
    logic                sleep_ack_bit = 1'b0;
    logic [KEY_BITS-1:0] key_lines     = '0;
    wire logic           chip_select;
    wire logic           serial_tick;
    wire logic           serial_in;
    wire logic           do_line;
    wire logic           dout_o;
    wire logic           dout_oe_n;
    wire logic [7:0]     disp_byte;
    wire logic           disp_strobe;
    logic [36:0]         w;
    int                  n;
    int                  strobes       = 0;
    int                  mismatches    = 0;
    int                  total_checks  = 0;

    key_request_link #(
        .AGREE_TICKS (AGREE),
        .RETRY_TICKS (RETRY),
        .DIV         (1)
    ) key_request_link_inst (
        .clock         (clock),
        .rst           (rst),
        .chip_select   (chip_select),
        .serial_tick   (serial_tick),
        .serial_in     (serial_in),
        .three_wire    (three_wire),
        .sleep_ack_bit (sleep_ack_bit),
        .key_lines     (key_lines),
        .dout_o        (dout_o),
        .dout_oe_n     (dout_oe_n),
        .disp_byte     (disp_byte),
        .disp_strobe   (disp_strobe)
    );

    key_host_model #(
        .GUARD (RETRY + 5)
    ) host (
        .clock       (clock),
        .three_wire  (three_wire),
        .dout_o      (dout_o),
        .dout_oe_n   (dout_oe_n),
        .chip_select (chip_select),
        .serial_tick (serial_tick),
        .serial_in   (serial_in),
        .do_line     (do_line)
    );

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    always @(posedge clock) begin
        if (disp_strobe === 1'b1) begin
            strobes <= strobes + 1;
        end
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // polls every cycle with the strobe low; a lost request ends the run
    task automatic wait_req;
        n = 0;
        while (do_line !== 1'b0) begin
            host.clk(1);
            n++;
            if (n > 300) begin
                check(do_line, 1'b0);
                tally_and_finish();
            end
        end
    endtask

    task automatic restart(input logic tw);
        key_lines  = '0;
        three_wire = tw;
        rst        = 1'b1;
        host.clk(3);
        rst = 1'b0;
        host.clk(4);
    endtask

    initial begin
        restart(1'b0);
        check(dout_oe_n, 1'b1);
        host.key_read(w);
        check(w[35:0], 36'h0);
        foreach (rows[i]) begin
            sleep_ack_bit = rows[i].sleep;
            key_lines     = rows[i].keys;
            wait_req();
            check(n >= AGREE && n <= AGREE + 10, 1'b1);
            host.key_read(w);
            check(w, rows[i].exp_word);
            host.write(DISP_WRITE_ADDR, rows[i].wbyte);
            check(disp_byte, rows[i].wbyte);
        end
        host.write(8'h41, 8'h99);
        check(strobes, 3);
        // keys change again before the first pass compares
        key_lines = 35'h000000010;
        host.clk(18);
        key_lines = 35'h000000020;
        wait_req();
        check(n + 18 >= RETRY && n + 18 <= RETRY + 10, 1'b1);
        host.key_read(w);
        check(w, 37'h1000000020);
        // host stalls until the buffer refuses the fifth scan
        for (int j = 1; j <= 5; j++) begin
            key_lines = 35'h1 << j;
            host.clk(AGREE + 15);
        end
        check(dout_oe_n, 1'b0);
        for (int j = 1; j <= 5; j++) begin
            host.key_read(w);
            check(w, {2'b10, 35'h1 << j});
        end
        check(dout_oe_n, 1'b1);
        host.serial_tick = 1'b1;
        restart(1'b1);
        host.command(START_CMD);
        key_lines = 35'h000000007;
        host.clk(RETRY + 20);
        check(dout_oe_n, 1'b1);
        host.key_read(w);
        check(w, 37'h1000000007);
        key_lines = 35'h000000009;
        wait_req();
        check(n >= AGREE && n <= AGREE + 10, 1'b1);
        restart(1'b1);
        host.command(START_CMD);
        key_lines = 35'h000000008;
        host.clk(RETRY + 20);
        check(dout_oe_n, 1'b1);
        host.command(STOP_CMD);
        wait_req();
        check(n <= 8, 1'b1);
        tally_and_finish();
    end
endmodule
`default_nettype wire
